// [hw/rpf_pkg.sv]
// rpf_pkg: shared constants for the radio payload queue and status block
package rpf_pkg;
    // =====================================================
    // register offsets
    localparam logic [4:0] ADDR_PIPE4_WIDTH  = 5'h15;
    localparam logic [4:0] ADDR_PIPE5_WIDTH  = 5'h16;
    localparam logic [4:0] ADDR_QUEUE_STATUS = 5'h17;
    // =====================================================
    // field positions and reset values
    localparam int         WIDTH_FIELD_MSB   = 5;
    localparam int         ST_TX_REUSE       = 6;
    localparam int         ST_TX_FULL        = 5;
    localparam int         ST_TX_EMPTY       = 4;
    localparam int         ST_RX_FULL        = 1;
    localparam int         ST_RX_EMPTY       = 0;
    localparam logic [5:0] WIDTH_RESET       = 6'h00;
    // =====================================================
    // payload shapes
    localparam int         QUEUE_DEPTH       = 3;
    localparam int         PAYLOAD_BITS      = 256;
    localparam int         LEN_BITS          = 6;
    localparam int         PIPE_BITS         = 3;
    localparam logic [2:0] PIPE_FOUR         = 3'h4;
    localparam logic [2:0] PIPE_FIVE         = 3'h5;
    // =====================================================
    // timing: least chip-enable high time for a resend
    localparam int         CLK_PERIOD_NS     = 25;
    localparam int         CE_MIN_NS         = 10000;
    localparam int         CE_MIN_CYCLES     = (CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         CE_CNT_W          = 9;
endpackage

// [hw/rpf_queue.sv]
// rpf_queue: small parameterised first-in first-out queue with flush
`timescale 1ns/1ps
module rpf_queue #(
    parameter int W     = 8,
    parameter int DEPTH = 3
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         push,
    input  wire logic [W-1:0]                 push_data,
    input  wire logic                         pop,
    input  wire logic                         flush,
    output logic      [W-1:0]                 head,
    output logic      [$clog2(DEPTH+1)-1:0]   count,
    output logic                              full,
    output logic                              empty
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic          next_full;
    logic          next_empty;
    logic          do_push;
    logic          do_pop;

    // =====================================================
    // next state; a push into a full queue is dropped unless a pop goes with it, never overwrites
    always_comb begin
        do_push     = push && !flush && (!full || pop);
        do_pop      = pop && !flush && !empty;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else begin
            if (do_push) begin
                next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                next_count = count + 1'b1;
            end else if (do_pop && !do_push) begin
                next_count = count - 1'b1;
            end
        end
        next_full  = (next_count == CNT_FULL);
        next_empty = (next_count == '0);
    end

    // =====================================================
    // registers; flags are flops so they move one cycle after the event
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            full   <= 1'b0;
            empty  <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            full   <= next_full;
            empty  <= next_empty;
        end
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    assign head = mem[rd_ptr];

    // =====================================================
    // checks
    property p_fill_flag;
        @(posedge clk) disable iff (rst)
        (push && !pop && !flush && count == CNT_FULL - 1'b1) |=> full && count == CNT_FULL;
    endproperty
    a_fill_flag: assert property (p_fill_flag) else $error("queue full flag late");

    property p_flush_empty;
        @(posedge clk) disable iff (rst)
        flush |=> empty && !full && count == '0;
    endproperty
    a_flush_empty: assert property (p_flush_empty) else $error("flush left data");

    property p_no_overflow;
        @(posedge clk) disable iff (rst)
        (full && push && !pop && !flush) |=> full && $stable(wr_ptr) && count == CNT_FULL;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("queue overflow");
endmodule

// [hw/rpf_top.sv]
// rpf_top: payload queues, acknowledge store and queue status register
`timescale 1ns/1ps
module rpf_top
    import rpf_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    // controller register commands
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [4:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    // controller payload commands
    input  wire logic                     tx_write,
    input  wire logic [LEN_BITS-1:0]      tx_write_len,
    input  wire logic [PAYLOAD_BITS-1:0]  tx_write_data,
    input  wire logic                     ack_write,
    input  wire logic [PIPE_BITS-1:0]     ack_write_pipe,
    input  wire logic [LEN_BITS-1:0]      ack_write_len,
    input  wire logic [PAYLOAD_BITS-1:0]  ack_write_data,
    input  wire logic                     resend_cmd,
    input  wire logic                     flush_tx,
    input  wire logic                     flush_rx,
    input  wire logic                     rx_read,
    output logic                          rx_read_valid,
    output logic      [PIPE_BITS-1:0]     rx_read_pipe,
    output logic      [LEN_BITS-1:0]      rx_read_len,
    output logic      [PAYLOAD_BITS-1:0]  rx_read_data,
    // radio side
    input  wire logic                     rx_mode,
    input  wire logic                     radio_ce,
    input  wire logic                     tx_req,
    output logic                          tx_out_valid,
    output logic                          resend_fire,
    output logic      [LEN_BITS-1:0]      tx_out_len,
    output logic      [PAYLOAD_BITS-1:0]  tx_out_data,
    input  wire logic                     rx_in_valid,
    input  wire logic [PIPE_BITS-1:0]     rx_in_pipe,
    input  wire logic [LEN_BITS-1:0]      rx_in_len,
    input  wire logic [PAYLOAD_BITS-1:0]  rx_in_data,
    output logic                          rx_drop,
    input  wire logic                     ack_req,
    input  wire logic [PIPE_BITS-1:0]     ack_req_pipe,
    output logic                          ack_out_valid,
    output logic      [LEN_BITS-1:0]      ack_out_len,
    output logic      [PAYLOAD_BITS-1:0]  ack_out_data
);
    localparam int TXW = LEN_BITS + PAYLOAD_BITS;
    localparam int RXW = PIPE_BITS + LEN_BITS + PAYLOAD_BITS;
    localparam int CW  = $clog2(QUEUE_DEPTH+1);
    localparam logic [CE_CNT_W-1:0] CE_LAST = CE_CNT_W'(CE_MIN_CYCLES - 1);
    localparam logic [CE_CNT_W-1:0] CE_TOP  = CE_CNT_W'(CE_MIN_CYCLES);

    // =====================================================
    // payload queues
    logic [TXW-1:0] tx_head;
    logic [RXW-1:0] rx_head;
    logic [CW-1:0]  tx_count;
    logic [CW-1:0]  rx_count;
    logic           tx_full;
    logic           tx_empty;
    logic           rx_full;
    logic           rx_empty;
    logic           tx_pop;
    logic           rx_push;
    logic           rx_pop;
    logic [LEN_BITS-1:0] rx_len_eff;

    rpf_queue #(.W(TXW), .DEPTH(QUEUE_DEPTH)) u_tx_queue (
        .clk       (clk),
        .rst       (rst),
        .push      (tx_write),
        .push_data ({tx_write_len, tx_write_data}),
        .pop       (tx_pop),
        .flush     (flush_tx),
        .head      (tx_head),
        .count     (tx_count),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    rpf_queue #(.W(RXW), .DEPTH(QUEUE_DEPTH)) u_rx_queue (
        .clk       (clk),
        .rst       (rst),
        .push      (rx_push),
        .push_data ({rx_in_pipe, rx_len_eff, rx_in_data}),
        .pop       (rx_pop),
        .flush     (flush_rx),
        .head      (rx_head),
        .count     (rx_count),
        .full      (rx_full),
        .empty     (rx_empty)
    );

    // =====================================================
    // control state
    logic [5:0]          pipe4_rx_width;
    logic [5:0]          pipe5_rx_width;
    logic                reuse;
    logic [CE_CNT_W-1:0] ce_cnt;
    logic                ce_s1;
    logic                ce_s2;
    logic [TXW-1:0]      last_sent;
    logic [7:0]          status_word;
    logic [5:0]          next_pipe4;
    logic [5:0]          next_pipe5;
    logic                next_reuse;
    logic [CE_CNT_W-1:0] next_ce_cnt;
    logic                fire_now;
    logic                pipe_unused;

    // pipe widths, reuse flag and the chip-enable hold counter
    always_comb begin
        next_pipe4 = pipe4_rx_width;
        next_pipe5 = pipe5_rx_width;
        if (reg_wr && reg_addr == ADDR_PIPE4_WIDTH) begin
            next_pipe4 = reg_wdata[WIDTH_FIELD_MSB:0];
        end else if (reg_wr && reg_addr == ADDR_PIPE5_WIDTH) begin
            next_pipe5 = reg_wdata[WIDTH_FIELD_MSB:0];
        end
        // set wins when a resend arrives together with a clearing command
        if (resend_cmd) begin
            next_reuse = 1'b1;
        end else if (tx_write || flush_tx) begin
            next_reuse = 1'b0;
        end else begin
            next_reuse = reuse;
        end
        // one resend per chip-enable pulse, only after the least hold time
        fire_now = reuse && ce_s2 && !rx_mode && ce_cnt == CE_LAST;
        if (!reuse || !ce_s2) begin
            next_ce_cnt = '0;
        end else if (ce_cnt != CE_TOP) begin
            next_ce_cnt = ce_cnt + 1'b1;
        end else begin
            next_ce_cnt = ce_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pipe4_rx_width <= WIDTH_RESET;
            pipe5_rx_width <= WIDTH_RESET;
            reuse          <= 1'b0;
            ce_cnt         <= '0;
            ce_s1          <= 1'b0;
            ce_s2          <= 1'b0;
        end else begin
            pipe4_rx_width <= next_pipe4;
            pipe5_rx_width <= next_pipe5;
            reuse          <= next_reuse;
            ce_cnt         <= next_ce_cnt;
            ce_s1          <= radio_ce;
            ce_s2          <= ce_s1;
        end
    end

    // status word; reserved bits read zero
    assign status_word = {1'b0, reuse, tx_full, tx_empty, 2'b00, rx_full, rx_empty};

    // =====================================================
    // queue movement
    always_comb begin
        // transmit queue feeds the radio only outside receive mode
        tx_pop      = tx_req && !rx_mode && !reuse && !tx_empty;
        pipe_unused = (rx_in_pipe == PIPE_FOUR && pipe4_rx_width == '0) ||
                      (rx_in_pipe == PIPE_FIVE && pipe5_rx_width == '0);
        if (rx_in_pipe == PIPE_FOUR) begin
            rx_len_eff = pipe4_rx_width;
        end else if (rx_in_pipe == PIPE_FIVE) begin
            rx_len_eff = pipe5_rx_width;
        end else begin
            rx_len_eff = rx_in_len;
        end
        rx_push = rx_in_valid && !pipe_unused && !rx_full && !flush_rx;
        rx_pop  = rx_read && !rx_empty;
    end

    // =====================================================
    // acknowledge store: slots kept packed in write order, oldest at zero
    logic                    ack_v [QUEUE_DEPTH];
    logic [PIPE_BITS-1:0]    ack_p [QUEUE_DEPTH];
    logic [TXW-1:0]          ack_d [QUEUE_DEPTH];
    logic                    next_ack_v [QUEUE_DEPTH];
    logic [PIPE_BITS-1:0]    next_ack_p [QUEUE_DEPTH];
    logic [TXW-1:0]          next_ack_d [QUEUE_DEPTH];
    logic                    ack_found;
    logic                    ack_take;
    logic [TXW-1:0]          ack_pick;
    logic [CW-1:0]           ack_count;

    always_comb begin
        int idx;
        int fill;
        idx       = 0;
        fill      = 0;
        ack_found = 1'b0;
        ack_pick  = ack_d[0];
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            next_ack_v[i] = ack_v[i];
            next_ack_p[i] = ack_p[i];
            next_ack_d[i] = ack_d[i];
            // lowest matching slot is the oldest for that pipe
            if (!ack_found && ack_v[i] && ack_p[i] == ack_req_pipe) begin
                ack_found = 1'b1;
                idx       = i;
                ack_pick  = ack_d[i];
            end
        end
        ack_take = ack_req && rx_mode && ack_found;
        if (ack_take) begin
            for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
                if (i >= idx) begin
                    next_ack_v[i] = ack_v[i+1];
                    next_ack_p[i] = ack_p[i+1];
                    next_ack_d[i] = ack_d[i+1];
                end
            end
            next_ack_v[QUEUE_DEPTH-1] = 1'b0;
        end
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            if (next_ack_v[i]) begin
                fill = fill + 1;
            end
        end
        // a fourth payload is refused, never overwrites a pending one
        if (ack_write && fill < QUEUE_DEPTH) begin
            next_ack_v[fill] = 1'b1;
            next_ack_p[fill] = ack_write_pipe;
            next_ack_d[fill] = {ack_write_len, ack_write_data};
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            if (rst) begin
                ack_v[i] <= 1'b0;
            end else begin
                ack_v[i] <= next_ack_v[i];
            end
            ack_p[i] <= next_ack_p[i];
            ack_d[i] <= next_ack_d[i];
        end
    end

    assign ack_count = CW'({1'b0, ack_v[0]} + {1'b0, ack_v[1]} + {1'b0, ack_v[2]});

    // =====================================================
    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata     <= 8'h00;
            rx_read_valid <= 1'b0;
            tx_out_valid  <= 1'b0;
            resend_fire   <= 1'b0;
            rx_drop       <= 1'b0;
            ack_out_valid <= 1'b0;
            rx_read_pipe  <= '0;
            rx_read_len   <= '0;
            rx_read_data  <= '0;
            tx_out_len    <= '0;
            tx_out_data   <= '0;
            ack_out_len   <= '0;
            ack_out_data  <= '0;
            last_sent     <= '0;
        end else begin
            if (reg_rd) begin
                if (reg_addr == ADDR_PIPE4_WIDTH) begin
                    reg_rdata <= {2'b00, pipe4_rx_width};
                end else if (reg_addr == ADDR_PIPE5_WIDTH) begin
                    reg_rdata <= {2'b00, pipe5_rx_width};
                end else if (reg_addr == ADDR_QUEUE_STATUS) begin
                    reg_rdata <= status_word;
                end else begin
                    reg_rdata <= 8'h00;
                end
            end
            rx_read_valid <= rx_pop;
            if (rx_pop) begin
                {rx_read_pipe, rx_read_len, rx_read_data} <= rx_head;
            end
            resend_fire  <= fire_now;
            tx_out_valid <= tx_pop || fire_now;
            if (tx_pop) begin
                {tx_out_len, tx_out_data} <= tx_head;
                last_sent                 <= tx_head;
            end else if (fire_now) begin
                {tx_out_len, tx_out_data} <= last_sent;
            end
            rx_drop       <= rx_in_valid && !rx_push;
            ack_out_valid <= ack_take;
            if (ack_take) begin
                {ack_out_len, ack_out_data} <= ack_pick;
            end
        end
    end

    // =====================================================
    // checks
    property p_reuse_set;
        @(posedge clk) disable iff (rst)
        resend_cmd |=> status_word[ST_TX_REUSE] ##1 (status_word[ST_TX_REUSE] || $past(tx_write || flush_tx));
    endproperty
    a_reuse_set: assert property (p_reuse_set) else $error("reuse flag not set");

    property p_reuse_clear;
        @(posedge clk) disable iff (rst)
        ((tx_write || flush_tx) && !resend_cmd) |=> !reuse && !resend_fire [*2];
    endproperty
    a_reuse_clear: assert property (p_reuse_clear) else $error("reuse flag not cleared");

    property p_resend_hold;
        @(posedge clk) disable iff (rst)
        $rose(resend_fire) |-> $past(ce_s2, 1) && $past(ce_cnt) == CE_LAST && $past(reuse);
    endproperty
    a_resend_hold: assert property (p_resend_hold) else $error("resend before hold time");

    property p_reset_status;
        @(posedge clk)
        $fell(rst) |-> status_word[ST_TX_EMPTY] && status_word[ST_RX_EMPTY] && !status_word[ST_TX_FULL];
    endproperty
    a_reset_status: assert property (p_reset_status) else $error("status reset value wrong");

    property p_tx_full_bit;
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == ADDR_QUEUE_STATUS |=> reg_rdata[ST_TX_FULL] == $past(tx_count == CW'(QUEUE_DEPTH));
    endproperty
    a_tx_full_bit: assert property (p_tx_full_bit) else $error("transmit full bit wrong");

    property p_rx_flags;
        @(posedge clk) disable iff (rst)
        reg_rd && reg_addr == ADDR_QUEUE_STATUS |=>
            reg_rdata[ST_RX_FULL] == $past(rx_count == CW'(QUEUE_DEPTH)) &&
            reg_rdata[ST_RX_EMPTY] == $past(rx_count == '0);
    endproperty
    a_rx_flags: assert property (p_rx_flags) else $error("receive flag bits wrong");

    property p_ack_cap;
        @(posedge clk) disable iff (rst)
        (ack_write && ack_count == CW'(QUEUE_DEPTH) && !ack_take) |=> ack_count == CW'(QUEUE_DEPTH) && $stable(ack_p[2]);
    endproperty
    a_ack_cap: assert property (p_ack_cap) else $error("acknowledge store overfilled");

    property p_ack_order;
        @(posedge clk) disable iff (rst)
        (ack_req && rx_mode && ack_v[0] && ack_p[0] == ack_req_pipe) |=>
            ack_out_valid && {ack_out_len, ack_out_data} == $past(ack_d[0]);
    endproperty
    a_ack_order: assert property (p_ack_order) else $error("acknowledge order broken");

    property p_ack_rx_only;
        @(posedge clk) disable iff (rst)
        (ack_req && !rx_mode) |=> !ack_out_valid;
    endproperty
    a_ack_rx_only: assert property (p_ack_rx_only) else $error("acknowledge sent outside receive");

    property p_unused_pipe;
        @(posedge clk) disable iff (rst)
        (rx_in_valid && !rx_read && !flush_rx &&
            ((rx_in_pipe == PIPE_FOUR && pipe4_rx_width == '0) ||
             (rx_in_pipe == PIPE_FIVE && pipe5_rx_width == '0))) |=> rx_drop && $stable(rx_count);
    endproperty
    a_unused_pipe: assert property (p_unused_pipe) else $error("unused pipe accepted data");

    property p_tx_mode_only;
        @(posedge clk) disable iff (rst)
        (tx_req && rx_mode) |=> !tx_out_valid || $past(fire_now);
    endproperty
    a_tx_mode_only: assert property (p_tx_mode_only) else $error("transmit fetch in receive mode");
endmodule

// [bench/rpf_radio_model.sv]
// rpf_radio_model: controller side chip enable driver for payload resends
`timescale 1ns/1ps
module rpf_radio_model
    import rpf_pkg::*;
(
    input  wire logic clk,
    input  wire logic go,
    output logic      radio_ce
);
    int n = 0;
    initial radio_ce = 1'b0;
    // =====================================================
    // chip enable
    // margin of 20 cycles past the least hold, so the sync delay cannot cut it short
    always @(posedge clk) begin
        if (go && n == 0) n <= CE_MIN_CYCLES + 20;
        else if (n > 0) n <= n - 1;
        radio_ce <= (n > 0);
    end
endmodule

// [bench/rpf_top_tb.sv]
// rpf_top_tb: self-checking bench for payload queues and queue status
`timescale 1ns/1ps
module rpf_top_tb
    import rpf_pkg::*;
;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, tx_write = 0, ack_write = 0, resend_cmd = 0, go = 0;
    logic flush_tx = 0, flush_rx = 0, rx_read = 0, rx_mode = 0, tx_req = 0, rx_in_valid = 0, ack_req = 0;
    logic [4:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [2:0] ack_write_pipe = 0, rx_in_pipe = 0, ack_req_pipe = 0, rx_read_pipe;
    logic [5:0] tx_write_len = 0, ack_write_len = 0, rx_in_len = 0, rx_read_len, tx_out_len, ack_out_len;
    logic [255:0] tx_write_data = 0, ack_write_data = 0, rx_in_data = 0, rx_read_data, tx_out_data, ack_out_data;
    logic rx_read_valid, tx_out_valid, resend_fire, rx_drop, ack_out_valid, radio_ce;
    logic [264:0] txq[$], rxq[$], akq[$], t;
    int err_count = 0, n_compared = 0, i;
    rpf_top uut (.*);
    rpf_radio_model pm (.clk(clk), .go(go), .radio_ce(radio_ce));
    always #12.5 clk = ~clk;
    // =====================================================
    // helpers; every strobe drops at the edge that takes it
    task finish_test;
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [265:0] g, input logic [265:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task e2;
        @(posedge clk);
        {reg_wr, reg_rd, tx_write, ack_write, resend_cmd, flush_tx} <= '0;
        {flush_rx, rx_read, tx_req, rx_in_valid, ack_req, go} <= '0;
        #1;
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1;
        reg_addr <= a;
        e2;
        chk(reg_rdata, e);
    endtask
    task txw;
        @(posedge clk);
        tx_write      <= 1;
        tx_write_len  <= $urandom_range(1, 32);
        tx_write_data <= {8{$urandom}};
        e2;
        if (txq.size() < 3) txq.push_back({tx_write_len, tx_write_data});
    endtask
    task rxi(input logic [2:0] p);
        logic d;
        @(posedge clk);
        rx_in_valid <= 1;
        rx_in_pipe  <= p;
        rx_in_len   <= $urandom_range(1, 32);
        rx_in_data  <= {8{$urandom}};
        e2;
        d = (p == 5) || rxq.size() == 3;
        if (!d) rxq.push_back({p, (p == 4) ? 6'h1F : rx_in_len, rx_in_data});
        chk(rx_drop, d);
    endtask
    task aw(input logic [2:0] p);
        @(posedge clk);
        ack_write      <= 1;
        ack_write_pipe <= p;
        ack_write_len  <= $urandom_range(1, 32);
        ack_write_data <= {8{$urandom}};
        e2;
        if (akq.size() < 3) akq.push_back({p, ack_write_len, ack_write_data});
    endtask
    task ar(input logic [2:0] p);
        int j;
        @(posedge clk);
        ack_req      <= 1;
        ack_req_pipe <= p;
        e2;
        for (j = 0; j < akq.size() && akq[j][264:262] !== p; j++);
        if (rx_mode && j < akq.size()) begin
            chk({ack_out_valid, ack_out_len, ack_out_data}, {1'b1, akq[j][261:0]});
            akq.delete(j);
        end else begin
            chk(ack_out_valid, 1'b0);
        end
    endtask
    // =====================================================
    // main sequence
    initial begin
        i = $urandom(49);
        repeat (3) @(posedge clk);
        rst <= 0;
        rd(ADDR_QUEUE_STATUS, 8'h11);
        rd(ADDR_PIPE5_WIDTH, 8'h00);
        rd(5'h1F, 8'h00);
        // transmit queue: overfill, then drain in order
        repeat (4) txw;
        rd(ADDR_QUEUE_STATUS, 8'h21);
        repeat (3) begin
            @(posedge clk);
            tx_req <= 1;
            e2;
            t = txq.pop_front();
            chk({tx_out_valid, tx_out_len, tx_out_data}, {1'b1, t[261:0]});
        end
        rd(ADDR_QUEUE_STATUS, 8'h11);
        // reuse: set, resend on long chip enable, cleared by flush and by a write
        @(posedge clk);
        resend_cmd <= 1;
        e2;
        rd(ADDR_QUEUE_STATUS, 8'h51);
        @(posedge clk);
        go <= 1;
        e2;
        // bounded wait; a missing resend counts as two errors and the run carries on to the verdict
        for (i = 0; i < 500 && resend_fire !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 500) err_count++;
        chk(i >= CE_MIN_CYCLES, 1'b1);
        chk({resend_fire, tx_out_valid, tx_out_len, tx_out_data}, {2'b11, t[261:0]});
        @(posedge clk);
        flush_tx <= 1;
        e2;
        txq.delete();
        rd(ADDR_QUEUE_STATUS, 8'h11);
        @(posedge clk);
        resend_cmd <= 1;
        e2;
        txw;
        rd(ADDR_QUEUE_STATUS, 8'h01);
        // receive queue: width register, drops, shared order, flush
        @(posedge clk);
        reg_wr    <= 1;
        reg_addr  <= ADDR_PIPE4_WIDTH;
        reg_wdata <= 8'hDF;
        e2;
        rd(ADDR_PIPE4_WIDTH, 8'h1F);
        rxi(5);
        for (i = 0; i < 4; i++) rxi((i == 1) ? 3'h2 : 3'h4);
        rd(ADDR_QUEUE_STATUS, 8'h02);
        repeat (3) begin
            @(posedge clk);
            rx_read <= 1;
            e2;
            chk({rx_read_valid, rx_read_pipe, rx_read_len, rx_read_data}, {1'b1, rxq.pop_front()});
        end
        rd(ADDR_QUEUE_STATUS, 8'h01);
        rxi(3);
        rd(ADDR_QUEUE_STATUS, 8'h00);
        @(posedge clk);
        flush_rx <= 1;
        e2;
        rxq.delete();
        rd(ADDR_QUEUE_STATUS, 8'h01);
        // acknowledge store: three pending at most, per pipe order
        for (i = 0; i < 4; i++) aw((i % 2) ? 3'h2 : 3'h1);
        ar(1);
        @(posedge clk);
        rx_mode <= 1;
        ar(1);
        ar(1);
        ar(2);
        ar(2);
        // transmit fetch refused in receive mode, served once back in transmit mode
        @(posedge clk);
        tx_req <= 1;
        e2;
        chk(tx_out_valid, 1'b0);
        @(posedge clk);
        rx_mode <= 0;
        @(posedge clk);
        tx_req <= 1;
        e2;
        t = txq.pop_front();
        chk({tx_out_valid, tx_out_len, tx_out_data}, {1'b1, t[261:0]});
        finish_test;
    end
endmodule
